// ===== rtl/tlcs_regs.svh
// Constants of the connection service engine
// Functional notes
// R1: Report remote-opened connection with id and address
// R2: Confirm local connection with session, id, address, port
// R3: Link layer sends only on established connections
// R4: Earlier send buffer fully precedes later one
// R5: Good send status means characters already copied
// R6: Good send status means accepted, maybe untransmitted
// R7: Send status: good, bad state, buffer, resources
// R8: Link layer retries send after resource refusal
// R9: Sent after acceptance; serial variant after transmission
// R10: Link layer receives only on established connections
// R11: Receive accepted while connection close pending
// R12: Second outstanding receive gets receive-pending status
// R13: Receive status: good, bad state, buffer, pending
// R14: Delivered count never exceeds receive buffer size
// R15: Deliveries ignore remote send boundaries
// R16: Deliveries need not align with frames
// R17: Closing connection may deliver zero-count confirmation
// R18: Link layer supplies encoded characters, exact count
// R19: Close reported only after all characters delivered; code takes a close in its first cycle even with a character queued for it
// R20: One receive-outstanding flag per connection
`ifndef TLCS_REGS_SVH
`define TLCS_REGS_SVH
`define TLCS_NCONN      4
`define TLCS_CONN_W     2
`define TLCS_CHAR_W     8
`define TLCS_SESS_W     8
`define TLCS_IP_W       32
`define TLCS_PORT_W     16
`define TLCS_SIZE_W     8
`define TLCS_SEND_MAX   4
`define TLCS_SLEN_W     3
`define TLCS_FIFO_DEPTH 8
`endif

// ===== rtl/tlcs_pkg.sv
// Types shared by the connection service engine
package tlcs_pkg;
  `include "tlcs_regs.svh"

  typedef logic [`TLCS_CONN_W-1:0] tlcs_conn_t;
  typedef logic [`TLCS_CHAR_W-1:0] tlcs_char_t;

  typedef enum logic [2:0] {
    TLCS_GOOD     = 3'h0,
    TLCS_INV_CONN = 3'h1,
    TLCS_INV_BUF  = 3'h2,
    TLCS_NO_RES   = 3'h3,
    TLCS_RCV_PEND = 3'h4
  } tlcs_status_e;

  typedef enum logic [1:0] {
    TLCS_TX_IDLE  = 2'h1,
    TLCS_TX_DRAIN = 2'h2
  } tlcs_txst_e;

  typedef struct packed {
    tlcs_conn_t conn;
    tlcs_char_t ch;
  } tlcs_txw_s;

  typedef struct packed {
    logic [`TLCS_SESS_W-1:0] sess;
    tlcs_conn_t              conn;
    logic [`TLCS_IP_W-1:0]   ip;
    logic [`TLCS_PORT_W-1:0] port;
  } tlcs_conninfo_s;
endpackage

// ===== rtl/tlcs_fifo.sv
// Character FIFO between send staging and transport
`timescale 1ns/10ps
module tlcs_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          push;
  logic          pop;

  assign in_ready = count_reg != DEPTH_C;
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      out_valid  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      out_valid <= count_next != '0;
    end
  end
endmodule

// ===== rtl/tlcs_slot.sv
// Per-connection state: open, closing and receive tracking
`timescale 1ns/10ps
module tlcs_slot #(
  parameter int SIZE_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              open_set,
  input  wire logic              close_set,
  input  wire logic              close_ack,
  input  wire logic              rcv_acc,
  input  wire logic [SIZE_W-1:0] rcv_size,
  input  wire logic              rx_take,
  input  wire logic              done_ack,
  output logic                   is_open,
  output logic                   closing,
  output logic                   pend,
  output logic [SIZE_W-1:0]      cnt,
  output logic [SIZE_W-1:0]      size,
  output logic                   want_done,
  output logic                   want_close,
  output logic                   rx_ready
);
  logic              pend_next;
  logic              closing_next;
  logic [SIZE_W-1:0] cnt_next;
  logic [SIZE_W-1:0] size_next;

  // R20: flag set on accept, cleared on confirmation
  assign pend_next    = rcv_acc || (pend && !done_ack);
  assign closing_next = close_set || (closing && !close_ack);
  assign cnt_next     = done_ack ? '0 : (rx_take ? cnt + 1'b1 : cnt);
  assign size_next    = rcv_acc ? rcv_size : size;

  // R15: flush whenever the stream pauses, ignoring send boundaries
  // R17: closing flushes even an empty buffer
  assign want_done  = pend && (cnt == size || closing ||
                               (cnt != '0 && !rx_take));
  // R19: close only once no receive is outstanding
  assign want_close = closing && !pend;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_open <= 1'b0;
    end else if (open_set) begin
      is_open <= 1'b1;
    end else if (close_ack) begin
      is_open <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend     <= 1'b0;
      closing  <= 1'b0;
      cnt      <= '0;
      size     <= '0;
      rx_ready <= 1'b0;
    end else begin
      pend    <= pend_next;
      closing <= closing_next;
      cnt     <= cnt_next;
      size    <= size_next;
      // R14: stop taking characters at the buffer size
      rx_ready <= pend_next && !closing_next && !done_ack &&
                  (cnt_next < size_next);
    end
  end
endmodule

// ===== rtl/tlcs_engine.sv
// Connection service engine: indications, send and receive
`timescale 1ns/10ps
`include "tlcs_regs.svh"
module tlcs_engine
  import tlcs_pkg::*;
#(
  parameter int FIFO_DEPTH  = `TLCS_FIFO_DEPTH,
  parameter bit SERIAL_PORT = 1'b0
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RESETN,
  input  wire logic                       TP_ACC_VALID,
  input  wire tlcs_conninfo_s             TP_ACC_INFO,
  input  wire logic                       TP_EST_VALID,
  input  wire tlcs_conninfo_s             TP_EST_INFO,
  input  wire logic                       TP_CLOSE_VALID,
  input  wire tlcs_conn_t                 TP_CLOSE_CONN,
  output logic                            TP_CLOSE_READY,
  input  wire logic                       TP_RX_VALID,
  input  wire tlcs_txw_s                  TP_RX_WORD,
  output logic [`TLCS_NCONN-1:0]          TP_RX_READY,
  output logic                            TP_TX_VALID,
  output tlcs_txw_s                       TP_TX_WORD,
  input  wire logic                       TP_TX_READY,
  output logic                            CONN_RCVD_IND,
  output tlcs_conninfo_s                  CONN_RCVD_INFO,
  output logic                            CONNECTED_IND,
  output tlcs_conninfo_s                  CONNECTED_INFO,
  input  wire logic                       SND_REQ,
  input  wire logic [`TLCS_SESS_W-1:0]    SND_SESS,
  input  wire tlcs_conn_t                 SND_CONN,
  input  wire logic [`TLCS_SLEN_W-1:0]    SND_LEN,
  input  wire logic [`TLCS_SEND_MAX*8-1:0] SND_BUF,
  output logic                            SND_ACK,
  output tlcs_status_e                    SND_RSP,
  output logic                            SENT_IND,
  output logic [`TLCS_SESS_W-1:0]         SENT_SESS,
  output tlcs_conn_t                      SENT_CONN,
  input  wire logic                       RCV_REQ,
  input  wire tlcs_conn_t                 RCV_CONN,
  input  wire logic [`TLCS_SIZE_W-1:0]    RCV_SIZE,
  input  wire logic                       RCV_BUF_OK,
  output logic                            RCV_ACK,
  output tlcs_status_e                    RCV_RSP,
  output logic                            RXD_VALID,
  output tlcs_txw_s                       RXD_WORD,
  output logic                            RCVD_IND,
  output tlcs_conn_t                      RCVD_CONN,
  output logic [`TLCS_SIZE_W-1:0]         RCVD_CNT,
  output logic                            CLOSED_IND,
  output tlcs_conn_t                      CLOSED_CONN
);
  localparam int NC = `TLCS_NCONN;
  localparam int SW = `TLCS_SIZE_W;

  logic [NC-1:0] is_open;
  logic [NC-1:0] closing;
  logic [NC-1:0] pend;
  logic [NC-1:0] want_done;
  logic [NC-1:0] want_close;
  logic [NC-1:0] rx_ready;
  logic [NC-1:0] done_ack;
  logic [NC-1:0] close_ack;
  logic [NC-1:0] rx_take;
  logic [NC-1:0] rcv_acc;
  logic [SW-1:0] cnt  [NC];
  logic [SW-1:0] size [NC];

  logic                       done_any;
  tlcs_conn_t                 done_sel;
  logic                       close_any;
  tlcs_conn_t                 close_sel;
  logic                       rx_hit;
  logic                       close_take;
  logic                       rcv_good;
  tlcs_status_e               rcv_status;
  logic                       snd_good;
  tlcs_status_e               snd_status;

  tlcs_txst_e                   tx_state_reg;
  logic [`TLCS_SEND_MAX*8-1:0]  hold_buf_reg;
  logic [`TLCS_SLEN_W-1:0]      hold_len_reg;
  logic [`TLCS_SLEN_W-1:0]      hold_idx_reg;
  logic [`TLCS_SESS_W-1:0]      hold_sess_reg;
  tlcs_conn_t                   hold_conn_reg;
  logic                         sent_wait_reg;
  logic                         push_valid;
  logic                         push_ready;
  logic                         push_last;
  tlcs_txw_s                    push_word;
  logic                         fifo_valid;
  tlcs_txw_s                    fifo_word;

  // Lowest connection wins each service; others wait a cycle
  always_comb begin
    done_any  = 1'b0;
    done_sel  = '0;
    close_any = 1'b0;
    close_sel = '0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (want_done[i]) begin
        done_any = 1'b1;
        done_sel = tlcs_conn_t'(i);
      end
      if (want_close[i]) begin
        close_any = 1'b1;
        close_sel = tlcs_conn_t'(i);
      end
    end
  end

  assign rx_hit = TP_RX_VALID && TP_RX_READY[TP_RX_WORD.conn];
  // R19: from its second cycle on, a close waits behind that connection's queued character
  assign close_take = TP_CLOSE_VALID && TP_CLOSE_READY;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_slot
      assign done_ack[g]  = done_any && done_sel == tlcs_conn_t'(g);
      assign close_ack[g] = close_any && close_sel == tlcs_conn_t'(g);
      assign rx_take[g]   = rx_hit && TP_RX_WORD.conn == tlcs_conn_t'(g);
      assign rcv_acc[g]   = rcv_good && RCV_CONN == tlcs_conn_t'(g);
      tlcs_slot #(
        .SIZE_W (SW)
      ) u_slot (
        .clk        (REF_CLK),
        .rst_n      (RESETN),
        .open_set   ((TP_ACC_VALID && TP_ACC_INFO.conn == tlcs_conn_t'(g))
                     || (TP_EST_VALID
                         && TP_EST_INFO.conn == tlcs_conn_t'(g))),
        .close_set  (close_take && TP_CLOSE_CONN == tlcs_conn_t'(g)),
        .close_ack  (close_ack[g]),
        .rcv_acc    (rcv_acc[g]),
        .rcv_size   (RCV_SIZE),
        .rx_take    (rx_take[g]),
        .done_ack   (done_ack[g]),
        .is_open    (is_open[g]),
        .closing    (closing[g]),
        .pend       (pend[g]),
        .cnt        (cnt[g]),
        .size       (size[g]),
        .want_done  (want_done[g]),
        .want_close (want_close[g]),
        .rx_ready   (rx_ready[g])
      );
    end
  endgenerate

  assign TP_RX_READY = rx_ready;

  // Connection indications
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CONN_RCVD_IND  <= 1'b0;
      CONN_RCVD_INFO <= '0;
      CONNECTED_IND  <= 1'b0;
      CONNECTED_INFO <= '0;
    end else begin
      // R1: remote-opened connection reported
      CONN_RCVD_IND <= TP_ACC_VALID;
      if (TP_ACC_VALID) begin
        CONN_RCVD_INFO <= TP_ACC_INFO;
      end
      // R2: locally initiated connection confirmed
      CONNECTED_IND <= TP_EST_VALID;
      if (TP_EST_VALID) begin
        CONNECTED_INFO <= TP_EST_INFO;
      end
    end
  end

  // Send status; holding register busy counts as no resources
  always_comb begin
    // R7: four send outcomes
    if (!is_open[SND_CONN] || closing[SND_CONN]) begin
      snd_status = TLCS_INV_CONN;
    end else if (SND_LEN == '0
                 || SND_LEN > `TLCS_SLEN_W'(`TLCS_SEND_MAX)) begin
      snd_status = TLCS_INV_BUF;
    end else if (tx_state_reg != TLCS_TX_IDLE || sent_wait_reg) begin
      snd_status = TLCS_NO_RES;
    end else begin
      snd_status = TLCS_GOOD;
    end
    snd_good = SND_REQ && snd_status == TLCS_GOOD;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SND_ACK <= 1'b0;
      SND_RSP <= TLCS_GOOD;
    end else begin
      // R6: good answers acceptance, not transmission
      SND_ACK <= SND_REQ;
      if (SND_REQ) begin
        SND_RSP <= snd_status;
      end
    end
  end

  assign push_valid = tx_state_reg == TLCS_TX_DRAIN;
  assign push_last  = hold_idx_reg == hold_len_reg - 1'b1;
  assign push_word  = '{conn: hold_conn_reg,
                        ch: hold_buf_reg[hold_idx_reg*8 +: 8]};

  // R5: buffer copied in the cycle the request is taken
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_state_reg  <= TLCS_TX_IDLE;
      hold_buf_reg  <= '0;
      hold_len_reg  <= '0;
      hold_idx_reg  <= '0;
      hold_sess_reg <= '0;
      hold_conn_reg <= '0;
    end else begin
      case (tx_state_reg)
        TLCS_TX_IDLE: begin
          if (snd_good) begin
            hold_buf_reg  <= SND_BUF;
            hold_len_reg  <= SND_LEN;
            hold_idx_reg  <= '0;
            hold_sess_reg <= SND_SESS;
            hold_conn_reg <= SND_CONN;
            tx_state_reg  <= TLCS_TX_DRAIN;
          end
        end
        TLCS_TX_DRAIN: begin
          // R4: one buffer drains whole before the next is taken
          if (push_ready) begin
            hold_idx_reg <= hold_idx_reg + 1'b1;
            if (push_last) begin
              tx_state_reg <= TLCS_TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TLCS_TX_IDLE;
      endcase
    end
  end

  // Back-pressure from the transport stalls the staging drain
  tlcs_fifo #(
    .W     ($bits(tlcs_txw_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .in_valid  (push_valid),
    .in_data   (push_word),
    .in_ready  (push_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (TP_TX_READY)
  );

  assign TP_TX_VALID = fifo_valid;
  assign TP_TX_WORD  = fifo_word;

  // R9: serial variant waits for the FIFO to empty
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SENT_IND      <= 1'b0;
      SENT_SESS     <= '0;
      SENT_CONN     <= '0;
      sent_wait_reg <= 1'b0;
    end else begin
      SENT_IND <= 1'b0;
      if (push_valid && push_ready && push_last) begin
        SENT_SESS <= hold_sess_reg;
        SENT_CONN <= hold_conn_reg;
        if (SERIAL_PORT) begin
          sent_wait_reg <= 1'b1;
        end else begin
          SENT_IND <= 1'b1;
        end
      end else if (sent_wait_reg && !fifo_valid) begin
        sent_wait_reg <= 1'b0;
        SENT_IND      <= 1'b1;
      end
    end
  end

  // Receive status
  always_comb begin
    // R11: a closing connection still takes receives
    // R13: four receive outcomes
    if (!is_open[RCV_CONN]) begin
      rcv_status = TLCS_INV_CONN;
    end else if (!RCV_BUF_OK || RCV_SIZE == '0) begin
      rcv_status = TLCS_INV_BUF;
    end else if (pend[RCV_CONN]) begin
      // R12: one outstanding receive per connection
      rcv_status = TLCS_RCV_PEND;
    end else begin
      rcv_status = TLCS_GOOD;
    end
    rcv_good = RCV_REQ && rcv_status == TLCS_GOOD;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RCV_ACK <= 1'b0;
      RCV_RSP <= TLCS_GOOD;
    end else begin
      RCV_ACK <= RCV_REQ;
      if (RCV_REQ) begin
        RCV_RSP <= rcv_status;
      end
    end
  end

  // Delivery of characters, confirmations and closes
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RXD_VALID      <= 1'b0;
      RXD_WORD       <= '0;
      RCVD_IND       <= 1'b0;
      RCVD_CONN      <= '0;
      RCVD_CNT       <= '0;
      CLOSED_IND     <= 1'b0;
      CLOSED_CONN    <= '0;
      TP_CLOSE_READY <= 1'b0;
    end else begin
      // R16: characters pass through with no frame alignment
      RXD_VALID <= rx_hit;
      if (rx_hit) begin
        RXD_WORD <= TP_RX_WORD;
      end
      RCVD_IND <= done_any;
      if (done_any) begin
        RCVD_CONN <= done_sel;
        RCVD_CNT  <= cnt[done_sel];
      end
      // R19: closed reported after the last confirmation
      CLOSED_IND <= close_any;
      if (close_any) begin
        CLOSED_CONN <= close_sel;
      end
      TP_CLOSE_READY <= !(TP_RX_VALID && TP_CLOSE_VALID
                          && TP_RX_WORD.conn == TP_CLOSE_CONN)
                        && !close_take;
    end
  end

  // Checks
  sequence s_send_good;
    SND_REQ && snd_status == TLCS_GOOD;
  endsequence

  sequence s_drain_end;
    push_valid && push_ready && push_last;
  endsequence

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  chk_conn_rcvd_ind: assert property ( // R1
    TP_ACC_VALID |=> CONN_RCVD_IND && CONN_RCVD_INFO == $past(TP_ACC_INFO))
    else $error("connect received indication missing");

  chk_connected_ind: assert property ( // R2
    TP_EST_VALID |=> CONNECTED_IND && CONNECTED_INFO == $past(TP_EST_INFO))
    else $error("connected confirmation missing");

  chk_send_copy: assert property ( // R5
    s_send_good |=> SND_ACK && SND_RSP == TLCS_GOOD
                    && hold_buf_reg == $past(SND_BUF))
    else $error("send buffer not copied with good status");

  chk_send_order: assert property ( // R4
    push_valid && push_ready && !push_last
      |=> push_valid && hold_idx_reg == $past(hold_idx_reg) + 1'b1)
    else $error("send characters out of order");

  chk_send_state: assert property ( // R7
    SND_REQ && !is_open[SND_CONN] |=> SND_ACK && SND_RSP == TLCS_INV_CONN)
    else $error("send on closed connection not refused");

  chk_sent_conf: assert property ( // R9
    (s_drain_end and (!SERIAL_PORT)) |=> SENT_IND)
    else $error("sent confirmation missing");

  chk_rcv_pending: assert property ( // R12
    RCV_REQ && is_open[RCV_CONN] && RCV_BUF_OK && RCV_SIZE != '0
      && pend[RCV_CONN] |=> RCV_ACK && RCV_RSP == TLCS_RCV_PEND)
    else $error("second receive not refused as pending");

  chk_rcv_limit: assert property ( // R14
    done_any |-> cnt[done_sel] <= size[done_sel])
    else $error("delivered count above buffer size");

  chk_close_drain: assert property ( // R19
    close_any |-> !pend[close_sel] ##1 CLOSED_IND)
    else $error("close reported with receive outstanding");

  chk_pend_flag: assert property ( // R20
    rcv_good |=> pend[$past(RCV_CONN)] [*1] ##0 RCV_RSP == TLCS_GOOD)
    else $error("receive flag not set on accept");
endmodule

// ===== sim/tlcs_transport.sv
// Behavioural transport partner: sink for sent and source of received chars
`timescale 1ns/10ps
`include "tlcs_regs.svh"
module tlcs_transport
  import tlcs_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   slow,
  input  wire logic                   tx_valid,
  input  wire tlcs_txw_s              tx_word,
  output logic                        tx_ready,
  output logic                        rx_valid,
  output tlcs_txw_s                   rx_word,
  input  wire logic [`TLCS_NCONN-1:0] rx_ready
);
  tlcs_txw_s txq[$];
  tlcs_txw_s rxq[$];
  tlcs_txw_s last;
  logic      tick;

  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_word  = '0;
    last     = '0;
    tick     = 1'b0;
  end

  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_word);
    end
    if (rx_valid && rx_ready[rx_word.conn]) begin
      last = rxq.pop_front();
    end
    #2;
    tick = ~tick;
    // Stall every other cycle in slow mode
    tx_ready = !slow || tick;
    rx_valid = rxq.size() > 0;
    // Idle word is scrambled so nothing stale looks valid
    rx_word = rx_valid ? rxq[0] : ~last;
  end
endmodule

// ===== sim/tape_link_connection_services_test.sv
// Self-checking bench for the connection service engine
`timescale 1ns/10ps
module tape_link_connection_services_test
  import tlcs_pkg::*;
;
  logic           REF_CLK, RESETN, TP_ACC_VALID, TP_EST_VALID, slow;
  logic           TP_CLOSE_VALID, TP_CLOSE_READY, TP_RX_VALID, TP_TX_VALID;
  logic           TP_TX_READY, CONN_RCVD_IND, CONNECTED_IND, SND_REQ;
  logic           SND_ACK, SENT_IND, RCV_REQ, RCV_BUF_OK, RCV_ACK;
  logic           RXD_VALID, RCVD_IND, CLOSED_IND;
  tlcs_conninfo_s TP_ACC_INFO, TP_EST_INFO, CONN_RCVD_INFO, CONNECTED_INFO;
  tlcs_conn_t     TP_CLOSE_CONN, SND_CONN, SENT_CONN, RCV_CONN;
  tlcs_conn_t     RCVD_CONN, CLOSED_CONN;
  tlcs_txw_s      TP_RX_WORD, TP_TX_WORD, RXD_WORD;
  tlcs_status_e   SND_RSP, RCV_RSP;
  logic [3:0]     TP_RX_READY;
  logic [7:0]     SND_SESS, SENT_SESS, RCV_SIZE, RCVD_CNT;
  logic [2:0]     SND_LEN;
  logic [31:0]    SND_BUF;
  logic [6:0]     inds;
  tlcs_txw_s      rxlog[$];
  int             num_errors = 0;
  int             comparisons = 0;

  assign inds = {CONNECTED_IND, CONN_RCVD_IND, CLOSED_IND, RCVD_IND,
                 SENT_IND, RCV_ACK, SND_ACK};

  tlcs_engine i_tlcs_engine (.REF_CLK, .RESETN, .TP_ACC_VALID, .TP_ACC_INFO,
    .TP_EST_VALID, .TP_EST_INFO, .TP_CLOSE_VALID, .TP_CLOSE_CONN,
    .TP_CLOSE_READY, .TP_RX_VALID, .TP_RX_WORD, .TP_RX_READY, .TP_TX_VALID,
    .TP_TX_WORD, .TP_TX_READY, .CONN_RCVD_IND, .CONN_RCVD_INFO,
    .CONNECTED_IND, .CONNECTED_INFO, .SND_REQ, .SND_SESS, .SND_CONN,
    .SND_LEN, .SND_BUF, .SND_ACK, .SND_RSP, .SENT_IND, .SENT_SESS,
    .SENT_CONN, .RCV_REQ, .RCV_CONN, .RCV_SIZE, .RCV_BUF_OK, .RCV_ACK,
    .RCV_RSP, .RXD_VALID, .RXD_WORD, .RCVD_IND, .RCVD_CONN, .RCVD_CNT,
    .CLOSED_IND, .CLOSED_CONN);

  tlcs_transport i_tlcs_transport (.clk(REF_CLK), .slow(slow),
    .tx_valid(TP_TX_VALID), .tx_word(TP_TX_WORD), .tx_ready(TP_TX_READY),
    .rx_valid(TP_RX_VALID), .rx_word(TP_RX_WORD), .rx_ready(TP_RX_READY));

  always @(posedge REF_CLK) begin
    if (RXD_VALID === 1'b1) begin
      rxlog.push_back(RXD_WORD);
    end
  end

  task automatic step();
    @(posedge REF_CLK);
    #2;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for a one-cycle indication
  task automatic wait_ind(int k, string what);
    int n;
    n = 0;
    while (inds[k] !== 1'b1 && n < 30) begin
      step();
      n++;
    end
    check(what, inds[k], 1);
  endtask

  task automatic snd(tlcs_conn_t c, logic [2:0] len, logic [31:0] b,
                     tlcs_status_e exp);
    step();
    SND_CONN = c;
    SND_LEN = len;
    SND_BUF = b;
    SND_REQ = 1'b1;
    step();
    SND_REQ = 1'b0;
    wait_ind(0, "send ack");
    check("send status", SND_RSP, exp);
  endtask

  task automatic rcv(tlcs_conn_t c, logic [7:0] sz, logic ok,
                     tlcs_status_e exp);
    step();
    RCV_CONN = c;
    RCV_SIZE = sz;
    RCV_BUF_OK = ok;
    RCV_REQ = 1'b1;
    step();
    RCV_REQ = 1'b0;
    wait_ind(1, "receive ack");
    check("receive status", RCV_RSP, exp);
  endtask

  task automatic t_connect();
    TP_EST_INFO = '{8'h5a, 2'h0, 32'h0a000002, 16'h1234};
    TP_EST_VALID = 1'b1;
    step();
    TP_EST_VALID = 1'b0;
    wait_ind(6, "connected");
    check("connected info", CONNECTED_INFO, TP_EST_INFO);
    TP_ACC_INFO = '{8'h00, 2'h1, 32'h0a000003, 16'h4321};
    TP_ACC_VALID = 1'b1;
    step();
    TP_ACC_VALID = 1'b0;
    wait_ind(5, "connect received");
    check("accept ip", {CONN_RCVD_INFO.conn, CONN_RCVD_INFO.ip},
          {2'h1, 32'h0a000003});
  endtask

  task automatic t_send();
    snd(2'h3, 3'h2, 32'h0, TLCS_INV_CONN);
    snd(2'h0, 3'h0, 32'h0, TLCS_INV_BUF);
    snd(2'h0, 3'h5, 32'h0, TLCS_INV_BUF);
    slow = 1'b1;
    snd(2'h0, 3'h4, 32'h44332211, TLCS_GOOD);
    // Refused with no resources while the first is still draining
    snd(2'h0, 3'h3, 32'hdeadbeef, TLCS_NO_RES);
    wait_ind(2, "sent");
    check("sent id", {SENT_SESS, SENT_CONN}, {8'h5a, 2'h0});
    repeat (5) step();
    snd(2'h0, 3'h3, 32'h00776655, TLCS_GOOD);
    wait_ind(2, "sent");
    repeat (20) step();
    check("tx count", i_tlcs_transport.txq.size(), 7);
    for (int i = 0; i < 7; i++) begin
      check("tx char", i_tlcs_transport.txq[i],
            {2'h0, 8'(8'h11 * (i + 1))});
    end
    slow = 1'b0;
  endtask

  task automatic t_receive();
    rcv(2'h3, 8'h2, 1'b1, TLCS_INV_CONN);
    rcv(2'h1, 8'h0, 1'b1, TLCS_INV_BUF);
    rcv(2'h1, 8'h2, 1'b0, TLCS_INV_BUF);
    rcv(2'h1, 8'h2, 1'b1, TLCS_GOOD);
    rcv(2'h1, 8'h2, 1'b1, TLCS_RCV_PEND);
    for (int i = 1; i < 4; i++) begin
      i_tlcs_transport.rxq.push_back({2'h1, 8'(8'ha0 + i)});
    end
    wait_ind(3, "received");
    check("rcvd count", {RCVD_CONN, RCVD_CNT}, {2'h1, 8'h2});
    rcv(2'h1, 8'h4, 1'b1, TLCS_GOOD);
    wait_ind(3, "received");
    check("rcvd count", {RCVD_CONN, RCVD_CNT}, {2'h1, 8'h1});
    check("rx count", rxlog.size(), 3);
    for (int i = 0; i < 3; i++) begin
      check("rx char", rxlog[i], {2'h1, 8'(8'ha1 + i)});
    end
  endtask

  task automatic t_close();
    int n;
    rcv(2'h1, 8'h4, 1'b1, TLCS_GOOD);
    TP_CLOSE_CONN = 2'h1;
    TP_CLOSE_VALID = 1'b1;
    n = 0;
    // Ready judged settled, before the edge that takes the close
    while (TP_CLOSE_READY !== 1'b1 && n < 30) begin
      step();
      n++;
    end
    check("close ready", TP_CLOSE_READY, 1);
    step();
    TP_CLOSE_VALID = 1'b0;
    wait_ind(3, "flush received");
    check("flush count", {RCVD_CONN, RCVD_CNT}, {2'h1, 8'h0});
    wait_ind(4, "closed");
    check("closed conn", CLOSED_CONN, 2'h1);
    rcv(2'h1, 8'h2, 1'b1, TLCS_INV_CONN);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  initial begin
    {RESETN, TP_ACC_VALID, TP_EST_VALID, TP_CLOSE_VALID, slow} = '0;
    {SND_REQ, RCV_REQ, RCV_BUF_OK, SND_LEN, SND_BUF, RCV_SIZE} = '0;
    {TP_ACC_INFO, TP_EST_INFO, TP_CLOSE_CONN, SND_CONN, RCV_CONN} = '0;
    SND_SESS = 8'h5a;
    repeat (6) @(posedge REF_CLK);
    #2;
    RESETN = 1'b1;
    step();
    t_connect();
    t_send();
    t_receive();
    t_close();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge REF_CLK);
    num_errors++;
    wrap_up();
  end
endmodule
